// file: common/fapes_defs.vh
// constants for the flash array program/erase sequencer
`ifndef FAPES_DEFS_VH
`define FAPES_DEFS_VH
// register byte offsets on the bus
`define FAPES_OFF_CTRL 12'h000
`define FAPES_OFF_PROT 12'h004
`define FAPES_OFF_STAT 12'h008
`define FAPES_OFF_ARR 12'h800
// control field positions
`define FAPES_CTRL_PROG 0
`define FAPES_CTRL_ERASE 1
`define FAPES_CTRL_MASS 2
`define FAPES_CTRL_HV 3
// status field positions
`define FAPES_ST_HV_REFUSED 0
`define FAPES_ST_ROW_FAIL 1
`define FAPES_ST_STANDBY 2
`define FAPES_ST_PROT_READ 3
`define FAPES_ST_ADDR_LATCHED 4
`define FAPES_ST_RECOVERING 5
// reset values
`define FAPES_CTRL_RST 4'h0
`define FAPES_PROT_RST 8'hff
// timing
`define FAPES_CLK_MHZ 100
`define FAPES_RCV_NS 1000
`define FAPES_RCV_CYC ((`FAPES_RCV_NS * `FAPES_CLK_MHZ) / 1000)
// array geometry, byte address bits
`define FAPES_ROW_LSB 6
`define FAPES_PAGE_LSB 7
`endif

// file: rtl/fapes_recovery_timer.v
// counts the read recovery time after high voltage is dropped
`timescale 1ns/1ps
`default_nettype none
`include "fapes_defs.vh"
module fapes_recovery_timer #(
  parameter CYCLES = `FAPES_RCV_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire start,
  output reg busy
);
  reg [15:0] cnt_q;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 16'h0000;
      busy <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= CYCLES[15:0];
      busy <= 1'b1;
    end
    else if (cnt_q != 16'h0000)
    begin
      cnt_q <= cnt_q - 16'h0001;
      busy <= (cnt_q != 16'h0001);
    end
  end
endmodule
`default_nettype wire

// file: rtl/fapes_protect_check.v
// decides whether an array address lies in the protected range
`timescale 1ns/1ps
`default_nettype none
`include "fapes_defs.vh"
module fapes_protect_check (
  input wire [7:0] prot,
  input wire [15:0] addr,
  output wire hit,
  output wire any_prot
);
  wire [15:0] start_addr;
  // all ones protects nothing; protect start is 1,prot,0000000
  assign start_addr = {1'b1, prot[6:0], 8'h00} | {8'h00, prot[0], 7'h00};
  assign any_prot = (prot != 8'hff);
  assign hit = any_prot && (addr >= {1'b1, prot, 7'h00});
  wire unused_ok;
  assign unused_ok = ^start_addr;
endmodule
`default_nettype wire

// file: rtl/fapes_top.v
// program/erase sequencer for the first flash array, with ahb-lite registers
// What this block does
// - refuse hv if mass erase is already set and protect is not all ones
// - reads blocked during recovery after hv drops
// - rows are 64 aligned bytes
// - program writes with hv on in two rows fail the cycle
// - prog_select latches program address and data
// - wait mode suspends operation into standby
// - stop mode suspends operation into standby
// - standby drives prog, erase, mass, hv and latch controls inactive; read enable and read address are not gated by standby
// - wait or stop in read mode changes nothing
// - hv only after prog/erase and proper steps
// - erase and prog_select never both set
// - hv blocked for protected target range
`timescale 1ns/1ps
`default_nettype none
`include "fapes_defs.vh"
module fapes_top #(
  parameter RCV_CYCLES = `FAPES_RCV_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [15:0] arr_addr,
  input wire [7:0] arr_wdata,
  input wire arr_wr,
  input wire arr_rd,
  input wire wait_mode,
  input wire stop_mode,
  output reg fl_prog,
  output reg fl_erase,
  output reg fl_mass,
  output reg fl_hv,
  output reg fl_latch,
  output reg [15:0] fl_addr,
  output reg [7:0] fl_data,
  output reg fl_read_en,
  output reg fl_standby
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SEL = 2'd1;
  localparam ST_PROT = 2'd2;
  localparam ST_ARMED = 2'd3;
  reg [1:0] seq_q;
  reg prog_q;
  reg erase_q;
  reg mass_q;
  reg hv_q;
  reg [7:0] prot_q;
  reg [15:0] tgt_q;
  reg tgt_prot_q;
  reg hv_refused_q;
  reg row_fail_q;
  reg standby_q;
  reg [11:0] a_addr_q;
  reg a_wr_q;
  reg a_rd_q;
  wire rcv_busy;
  wire hv_fall;
  wire tgt_hit;
  wire any_prot;
  wire arr_hit;
  wire lowpower;
  wire wr_ctrl;
  wire wr_prot;
  wire rd_prot;
  wire [3:0] wctl;
  function is_reg;
    input [11:0] a;
    input [11:0] off;
    begin
      is_reg = (a[11:2] == off[11:2]);
    end
  endfunction
  assign lowpower = wait_mode | stop_mode;
  assign wr_ctrl = a_wr_q && is_reg(a_addr_q, `FAPES_OFF_CTRL);
  assign wr_prot = a_wr_q && is_reg(a_addr_q, `FAPES_OFF_PROT);
  assign rd_prot = a_rd_q && is_reg(a_addr_q, `FAPES_OFF_PROT);
  assign wctl = hwdata[3:0];
  assign hv_fall = hv_q && wr_ctrl && !wctl[`FAPES_CTRL_HV];
  fapes_protect_check u_prot (
    .prot(prot_q),
    .addr(tgt_q),
    .hit(tgt_hit),
    .any_prot(any_prot)
  );
  assign arr_hit = tgt_hit;
  fapes_recovery_timer #(
    .CYCLES(RCV_CYCLES)
  ) u_rcv (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(hv_fall),
    .busy(rcv_busy)
  );
  // ahb address phase capture; slave always ready, always okay
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_addr_q <= 12'h000;
      a_wr_q <= 1'b0;
      a_rd_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (hready)
    begin
      a_addr_q <= haddr;
      a_wr_q <= hsel && htrans[1] && hwrite;
      a_rd_q <= hsel && htrans[1] && !hwrite;
    end
  end
  // control bits and sequence tracking
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {hv_q, mass_q, erase_q, prog_q} <= `FAPES_CTRL_RST;
      prot_q <= `FAPES_PROT_RST;
      seq_q <= ST_IDLE;
      tgt_q <= 16'h0000;
      tgt_prot_q <= 1'b0;
      hv_refused_q <= 1'b0;
      row_fail_q <= 1'b0;
      standby_q <= 1'b0;
    end
    else
    begin
      standby_q <= lowpower && (prog_q || erase_q || hv_q);
      if (wr_ctrl)
      begin
        if (wctl[`FAPES_CTRL_PROG] && !(erase_q || wctl[`FAPES_CTRL_ERASE]))
          prog_q <= 1'b1;
        else if (!wctl[`FAPES_CTRL_PROG])
          prog_q <= 1'b0;
        if (wctl[`FAPES_CTRL_ERASE] && !(prog_q || wctl[`FAPES_CTRL_PROG]))
          erase_q <= 1'b1;
        else if (!wctl[`FAPES_CTRL_ERASE])
          erase_q <= 1'b0;
        mass_q <= wctl[`FAPES_CTRL_MASS];
        if (!wctl[`FAPES_CTRL_PROG] && !wctl[`FAPES_CTRL_ERASE] && !wctl[`FAPES_CTRL_HV])
          seq_q <= ST_IDLE;
        else if (seq_q == ST_IDLE && (wctl[`FAPES_CTRL_PROG] ^ wctl[`FAPES_CTRL_ERASE]))
          seq_q <= ST_SEL;
        if (wctl[`FAPES_CTRL_HV] && !hv_q)
        begin
          // hv needs selected op and steps
          // mass needs no protection at all
          if ((prog_q || erase_q) && seq_q == ST_ARMED && !tgt_prot_q
              && !(erase_q && mass_q && any_prot))
            hv_q <= 1'b1;
          else
            hv_refused_q <= 1'b1;
        end
        else if (!wctl[`FAPES_CTRL_HV])
          hv_q <= 1'b0;
      end
      else if (wr_prot)
        hv_refused_q <= 1'b0;
      // protect read between select and hv
      if (rd_prot && seq_q == ST_SEL)
        seq_q <= ST_PROT;
      // page chosen by the write address
      if (arr_wr && seq_q == ST_PROT && !lowpower)
      begin
        seq_q <= ST_ARMED;
        tgt_q <= arr_addr;
        row_fail_q <= 1'b0;
      end
      tgt_prot_q <= arr_hit;
      // row is address bits six and up
      if (arr_wr && prog_q && hv_q && seq_q == ST_ARMED &&
          arr_addr[15:`FAPES_ROW_LSB] != tgt_q[15:`FAPES_ROW_LSB])
        row_fail_q <= 1'b1;
      if (wr_ctrl && hwdata[8] && !prog_q && !erase_q)
        prot_q <= hwdata[23:16];
    end
  end
  // flash array control outputs, all registered
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
      fl_mass <= 1'b0;
      fl_hv <= 1'b0;
      fl_latch <= 1'b0;
      fl_addr <= 16'h0000;
      fl_data <= 8'h00;
      fl_read_en <= 1'b0;
      fl_standby <= 1'b0;
    end
    else
    begin
      fl_standby <= standby_q;
      fl_prog <= prog_q && !standby_q && !row_fail_q;
      fl_erase <= erase_q && !standby_q;
      fl_mass <= erase_q && mass_q && !standby_q;
      fl_hv <= hv_q && !standby_q && !row_fail_q;
      // program mode latches address and data
      fl_latch <= prog_q && arr_wr && !standby_q;
      if (arr_wr && !standby_q && (prog_q || erase_q))
      begin
        fl_addr <= arr_addr;
        fl_data <= arr_wdata;
      end
      else if (arr_rd)
        fl_addr <= arr_addr;
      fl_read_en <= arr_rd && !hv_q && !prog_q && !erase_q && !rcv_busy;
    end
  end
  // read data mux
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      if (is_reg(haddr, `FAPES_OFF_CTRL))
        hrdata <= {28'h0000000, hv_q, mass_q, erase_q, prog_q};
      else if (is_reg(haddr, `FAPES_OFF_PROT))
        hrdata <= {24'h000000, prot_q};
      else if (is_reg(haddr, `FAPES_OFF_STAT))
        hrdata <= {26'h0000000, rcv_busy, seq_q == ST_ARMED, seq_q == ST_PROT,
                   standby_q, row_fail_q, hv_refused_q};
      else
        hrdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// file: tb/fapes_top_asserts.sv
// port-level assertions for the flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module fapes_top_asserts #(
  parameter RCV_CYCLES = 100
) (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire arr_wr,
  input wire arr_rd,
  input wire wait_mode,
  input wire stop_mode,
  input wire fl_prog,
  input wire fl_erase,
  input wire fl_mass,
  input wire fl_hv,
  input wire fl_latch,
  input wire fl_read_en,
  input wire fl_standby
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("slave not ready or not okay");
  property p_intlk; !(fl_prog && fl_erase); endproperty
  a_intlk: assert property (p_intlk) else $error("prog and erase both on");
  property p_stby; fl_standby |-> !(fl_prog || fl_erase || fl_mass || fl_hv || fl_latch); endproperty
  a_stby: assert property (p_stby) else $error("control active in standby");
  property p_hvsrc; $rose(fl_hv) |-> fl_prog || fl_erase; endproperty
  a_hvsrc: assert property (p_hvsrc) else $error("hv with no operation");
  property p_susp; (wait_mode || stop_mode) && fl_hv |-> ##[1:2] fl_standby; endproperty
  a_susp: assert property (p_susp) else $error("operation not suspended");
  property p_latch; fl_latch |-> fl_prog && ($past(arr_wr) || $past(arr_wr, 2)); endproperty
  a_latch: assert property (p_latch) else $error("latch without program write");
  property p_rd; fl_read_en |-> !fl_hv && ($past(arr_rd) || $past(arr_rd, 2)); endproperty
  a_rd: assert property (p_rd) else $error("read enable without read");
  // recovery is at least a few cycles even with a shortened count
  property p_rcv; fl_read_en |-> !$past(fl_hv, 2) && !$past(fl_hv, 3); endproperty
  a_rcv: assert property (p_rcv) else $error("read inside recovery");
  property p_wake; $rose(fl_standby) |-> wait_mode || stop_mode || $past(wait_mode || stop_mode); endproperty
  a_wake: assert property (p_wake) else $error("standby without low power mode");
  c_latch: cover property (fl_latch);
  c_stby: cover property (fl_standby);
  c_read: cover property (fl_read_en);
endmodule
bind fapes_top fapes_top_asserts #(.RCV_CYCLES(RCV_CYCLES)) fapes_top_asserts_i (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .arr_wr(arr_wr), .arr_rd(arr_rd), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_mass(fl_mass), .fl_hv(fl_hv),
  .fl_latch(fl_latch), .fl_read_en(fl_read_en), .fl_standby(fl_standby)
);
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fapes_defs.vh"
`define CHK(g, e) chk(g, e)
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, arr_wr = 0, arr_rd = 0;
  logic wait_mode = 0, stop_mode = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] hwdata = 0, rd;
  logic [15:0] arr_addr = 0;
  logic [7:0] arr_wdata = 0;
  wire [31:0] hrdata;
  wire [15:0] fl_addr;
  wire [7:0] fl_data;
  wire hreadyout, hresp, fl_prog, fl_erase, fl_mass, fl_hv, fl_latch, fl_read_en, fl_standby;
  int errors = 0, total_checks = 0, cyc_n = 0, lat = 0, rds = 0, n;
  always #5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc_n <= cyc_n + 1;
    lat <= lat + fl_latch;
    rds <= rds + fl_read_en;
    if (cyc_n > 5000)
    begin
      errors++;
      finish_test;
    end
  end
  // a short recovery count keeps the read tests quick
  fapes_top #(.RCV_CYCLES(4)) fapes_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wr(arr_wr), .arr_rd(arr_rd),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .fl_prog(fl_prog), .fl_erase(fl_erase),
    .fl_mass(fl_mass), .fl_hv(fl_hv), .fl_latch(fl_latch), .fl_addr(fl_addr),
    .fl_data(fl_data), .fl_read_en(fl_read_en), .fl_standby(fl_standby));
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task arr(input logic [15:0] a, input logic w);
    @(posedge hclk);
    arr_addr <= a;
    arr_wdata <= a[7:0];
    arr_wr <= w;
    arr_rd <= !w;
    @(posedge hclk);
    arr_wr <= 0;
    arr_rd <= 0;
    cyc(3);
  endtask
  // select, optional protect read, arming write, then ask for hv
  task seq(input logic [3:0] c, input logic p, input logic [15:0] a);
    bus(1, `FAPES_OFF_CTRL, {28'h0, c});
    if (p)
      bus(0, `FAPES_OFF_PROT, 0);
    arr(a, 1);
    bus(1, `FAPES_OFF_CTRL, {28'h0, c | 4'h8});
    cyc(3);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    bus(0, `FAPES_OFF_CTRL, 0);
    `CHK(rd, 0);
    bus(0, `FAPES_OFF_PROT, 0);
    `CHK(rd, 32'hff);
    bus(0, 12'h00c, 0);
    `CHK(rd, 0);
    bus(1, `FAPES_OFF_CTRL, 3);
    bus(0, `FAPES_OFF_CTRL, 0);
    `CHK(rd, 0);
    $display("test reset and interlock done");
    seq(1, 1, 16'h8040);
    `CHK({fl_prog, fl_hv}, 2'h3);
    `CHK({hreadyout, hresp}, 2'h2);
    n = lat;
    arr(16'h8041, 1);
    `CHK(lat - n, 1);
    `CHK({fl_addr, fl_data}, 24'h804141);
    arr(16'h8080, 1);
    bus(0, `FAPES_OFF_STAT, 0);
    `CHK(rd[1], 1);
    `CHK(fl_hv, 0);
    bus(1, `FAPES_OFF_CTRL, 0);
    $display("test program done");
    seq(2, 1, 16'h8100);
    `CHK({fl_erase, fl_hv}, 2'h3);
    `CHK(fl_mass, 0);
    for (int i = 1; i < 3; i++)
    begin
      @(posedge hclk);
      {stop_mode, wait_mode} <= 2'(i);
      cyc(3);
      `CHK({fl_standby, fl_hv, fl_erase}, 3'h4);
      @(posedge hclk);
      {stop_mode, wait_mode} <= 2'h0;
      cyc(3);
      `CHK({fl_standby, fl_hv, fl_erase}, 3'h3);
    end
    bus(1, `FAPES_OFF_CTRL, 8);
    bus(1, `FAPES_OFF_CTRL, 0);
    n = rds;
    arr(16'h8100, 0);
    `CHK(rds - n, 0);
    cyc(8);
    arr(16'h8100, 0);
    `CHK(rds - n, 1);
    $display("test erase standby recovery done");
    bus(1, `FAPES_OFF_CTRL, 32'h00fe0100);
    bus(0, `FAPES_OFF_PROT, 0);
    `CHK(rd, 32'hfe);
    seq(6, 1, 16'h8000);
    `CHK(fl_hv, 0);
    `CHK({fl_erase, fl_mass}, 2'h3);
    bus(0, `FAPES_OFF_STAT, 0);
    `CHK(rd[0], 1);
    bus(0, `FAPES_OFF_CTRL, 0);
    `CHK(rd, 6);
    bus(1, `FAPES_OFF_CTRL, 0);
    bus(1, `FAPES_OFF_PROT, 0);
    seq(2, 1, 16'hff00);
    `CHK(fl_hv, 0);
    bus(1, `FAPES_OFF_CTRL, 0);
    seq(2, 0, 16'h8000);
    `CHK(fl_hv, 0);
    bus(1, `FAPES_OFF_CTRL, 0);
    seq(2, 1, 16'h8000);
    `CHK(fl_hv, 1);
    bus(1, `FAPES_OFF_CTRL, 0);
    $display("test refusals done");
    cyc(8);
    @(posedge hclk);
    wait_mode <= 1;
    cyc(3);
    `CHK(fl_standby, 0);
    bus(0, `FAPES_OFF_PROT, 0);
    `CHK(rd, 32'hfe);
    $display("test read mode wait done");
    finish_test;
  end
endmodule
`default_nettype wire
